//--- verilog/mra_pkg.sv
// Purpose: Shared constants and types for the mode register access block
// Assumes: Command pins and link clock arrive from the controller's domain
// Notes:   Link clock is sampled, never used as a clock
package mra_pkg;
  localparam int          CA_W        = 6;
  localparam int          DQ_W        = 16;
  localparam int          REG_N       = 64;
  // Command opcodes on cmd_addr_bus[4:0] of the first command cycle
  localparam logic [4:0]  OPC_MRW1    = 5'h06;
  localparam logic [4:0]  OPC_MRW2    = 5'h16;
  localparam logic [4:0]  OPC_MRR1    = 5'h0e;
  localparam int          OPC_HI_BIT  = 5;
  // Latency and burst figures, in link clock cycles, unit intervals and ns
  localparam logic [7:0]  READ_LATENCY = 8'h0e;
  localparam logic [4:0]  BURST_UI     = 5'h10;
  localparam logic [4:0]  REG_DATA_UI  = 5'h04;
  localparam int          LINK_TCK_NS  = 160;
  localparam int          WTR_NS       = 10;
  localparam int          WTR_CYC_I    = (WTR_NS + LINK_TCK_NS - 1) / LINK_TCK_NS;
  localparam logic [3:0]  WTR_CYC      = WTR_CYC_I[3:0];
  // Inversion enable sits in one writable register
  localparam logic [5:0]  DBI_REG      = 6'h03;
  localparam int          DBI_BIT      = 6;
  localparam logic [3:0]  DBI_LIMIT    = 4'h4;
  // Read-only registers: 0 and 5 to 8; value is arbitrary
  localparam logic [63:0] RO_MASK      = 64'h0000_0000_0000_01e1;
  localparam logic [7:0]  RO_VALUE     = 8'h5a;
  localparam logic [7:0]  REG_RST      = 8'h00;

  typedef struct packed {
    logic            link_ck;
    logic            cke;
    logic            cs;
    logic [CA_W-1:0] ca;
  } mra_pins_s;

  typedef enum {ST_IDLE, ST_MRR2, ST_MRW1_2, ST_MRW2_2} mra_st_e;
endpackage : mra_pkg

//--- verilog/mra_core.sv
// Purpose: Device-side mode register read and write handling on one channel
// Assumes: Controller keeps all command spacing; commands are not checked
// Notes:   Read data leaves one unit interval per sampled link clock edge
module mra_core
  import mra_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys_in,
  input  wire logic            rst_b_in,
  // Command pins from the controller
  input  wire logic            link_ck_in,
  input  wire logic            cke_in,
  input  wire logic            cs_in,
  input  wire logic [CA_W-1:0] ca_in,
  // Write datapath: last write strobe latched, same clock
  input  wire logic            wr_last_strobe_in,
  // Read data pins
  output logic [DQ_W-1:0]      dq_out,
  output logic                 dq_oe_out,
  output logic                 dmi_out,
  output logic                 dmi_oe_out,
  // Status
  output logic                 rd_busy_out,
  output logic                 wtr_busy_out
);
  mra_pins_s       sync1_ff, sync2_ff;
  logic            ck3_ff;
  mra_st_e         st_ff, nxt_st;
  logic [5:0]      wa_ff, nxt_wa, ra_ff, nxt_ra;
  logic            op7_ff, nxt_op7, op6_ff, nxt_op6;
  logic            pend_ff, nxt_pend, act_ff, nxt_act;
  logic [7:0]      lat_ff, nxt_lat;
  logic [4:0]      ui_ff, nxt_ui;
  logic [7:0]      byte_ff, nxt_byte;
  logic            inv_ff, nxt_inv;
  logic [DQ_W-1:0] dq_ff, nxt_dq;
  logic            oe_ff, nxt_oe, dmi_ff, nxt_dmi;
  logic            arm_ff, nxt_arm;
  logic [3:0]      wtr_ff, nxt_wtr;
  logic [7:0]      mem_ff [REG_N];
  logic            mem_we;
  logic [7:0]      mem_wd;
  logic            rise, fall, busy;
  logic [7:0]      rd_byte;
  mra_pins_s       cmd;

  function automatic logic is_ro(input logic [5:0] a);
    is_ro = RO_MASK[a];
  endfunction : is_ro

  function automatic logic [3:0] ones(input logic [7:0] b);
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + {3'h0, b[i]};
    end
  endfunction : ones

  // Two stages before any decode; third stage only for edge finding
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      ck3_ff   <= 1'b0;
    end else begin
      sync1_ff <= '{link_ck: link_ck_in, cke: cke_in, cs: cs_in, ca: ca_in};
      sync2_ff <= sync1_ff;
      ck3_ff   <= sync2_ff.link_ck;
    end
  end

  assign cmd     = sync2_ff;
  assign rise    = cmd.link_ck & ~ck3_ff;
  assign fall    = ~cmd.link_ck & ck3_ff;
  assign busy    = pend_ff | act_ff;
  assign rd_byte = is_ro(ra_ff) ? RO_VALUE : mem_ff[ra_ff];

  always_comb begin
    nxt_st   = st_ff;
    nxt_wa   = wa_ff;
    nxt_ra   = ra_ff;
    nxt_op7  = op7_ff;
    nxt_op6  = op6_ff;
    nxt_pend = pend_ff;
    nxt_act  = act_ff;
    nxt_lat  = lat_ff;
    nxt_ui   = ui_ff;
    nxt_byte = byte_ff;
    nxt_inv  = inv_ff;
    nxt_dq   = dq_ff;
    nxt_oe   = oe_ff;
    nxt_dmi  = dmi_ff;
    nxt_arm  = arm_ff | wr_last_strobe_in;
    nxt_wtr  = wtr_ff;
    mem_we   = 1'b0;
    mem_wd   = {op7_ff, op6_ff, cmd.ca};
    if (rise) begin
      // Bank state is not consulted: writes act the same either way
      case (st_ff)
        ST_IDLE: begin
          // Busy reads swallow commands; only deselects are expected
          if (cmd.cke && cmd.cs && !busy) begin
            case (cmd.ca[4:0])
              OPC_MRR1: nxt_st = ST_MRR2;
              OPC_MRW1: begin
                nxt_op7 = cmd.ca[OPC_HI_BIT];
                nxt_st  = ST_MRW1_2;
              end
              OPC_MRW2: begin
                nxt_op6 = cmd.ca[OPC_HI_BIT];
                nxt_st  = ST_MRW2_2;
              end
              default: nxt_st = ST_IDLE;
            endcase
          end
        end
        ST_MRR2: begin
          nxt_ra   = cmd.ca;
          nxt_lat  = READ_LATENCY;
          nxt_pend = 1'b1;
          nxt_st   = ST_IDLE;
        end
        ST_MRW1_2: begin
          nxt_wa = cmd.ca;
          nxt_st = ST_IDLE;
        end
        ST_MRW2_2: begin
          mem_we = ~is_ro(wa_ff);
          nxt_st = ST_IDLE;
        end
        default: nxt_st = ST_IDLE;
      endcase
      if (pend_ff && lat_ff != 8'h00) begin
        nxt_lat = lat_ff - 8'h01;
      end else if (pend_ff) begin
        // Inversion chosen once so all intervals of the burst agree
        nxt_inv  = mem_ff[DBI_REG][DBI_BIT] && ones(rd_byte) > DBI_LIMIT;
        nxt_byte = nxt_inv ? ~rd_byte : rd_byte;
        nxt_pend = 1'b0;
        nxt_act  = 1'b1;
        nxt_ui   = 5'h00;
      end
      // Turnaround starts on the first rising edge after the strobe
      if (arm_ff) begin
        nxt_arm = wr_last_strobe_in;
        nxt_wtr = WTR_CYC;
      end else if (wtr_ff != 4'h0) begin
        nxt_wtr = wtr_ff - 4'h1;
      end
    end
    if ((rise || fall) && act_ff && !(rise && pend_ff)) begin
      if (ui_ff < BURST_UI) begin
        nxt_oe  = 1'b1;
        nxt_dmi = inv_ff;
        // Later intervals are undefined; zero keeps them quiet
        nxt_dq  = (ui_ff < REG_DATA_UI) ? {8'h00, byte_ff} : '0;
        nxt_ui  = ui_ff + 5'h01;
      end else begin
        nxt_oe  = 1'b0;
        nxt_dmi = 1'b0;
        nxt_dq  = '0;
        nxt_act = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st_ff   <= ST_IDLE;
      wa_ff   <= 6'h00;
      ra_ff   <= 6'h00;
      op7_ff  <= 1'b0;
      op6_ff  <= 1'b0;
      pend_ff <= 1'b0;
      act_ff  <= 1'b0;
      lat_ff  <= 8'h00;
      ui_ff   <= 5'h00;
      byte_ff <= 8'h00;
      inv_ff  <= 1'b0;
      dq_ff   <= '0;
      oe_ff   <= 1'b0;
      dmi_ff  <= 1'b0;
      arm_ff  <= 1'b0;
      wtr_ff  <= 4'h0;
    end else begin
      st_ff   <= nxt_st;
      wa_ff   <= nxt_wa;
      ra_ff   <= nxt_ra;
      op7_ff  <= nxt_op7;
      op6_ff  <= nxt_op6;
      pend_ff <= nxt_pend;
      act_ff  <= nxt_act;
      lat_ff  <= nxt_lat;
      ui_ff   <= nxt_ui;
      byte_ff <= nxt_byte;
      inv_ff  <= nxt_inv;
      dq_ff   <= nxt_dq;
      oe_ff   <= nxt_oe;
      dmi_ff  <= nxt_dmi;
      arm_ff  <= nxt_arm;
      wtr_ff  <= nxt_wtr;
    end
  end

  // Register array kept apart so reset does not fan out through a mux tree
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_N; i++) begin
        mem_ff[i] <= REG_RST;
      end
    end else if (mem_we) begin
      mem_ff[wa_ff] <= mem_wd;
    end
  end

  assign dq_out       = dq_ff;
  assign dq_oe_out    = oe_ff;
  assign dmi_out      = dmi_ff;
  assign dmi_oe_out   = oe_ff;
  assign rd_busy_out  = busy;
  assign wtr_busy_out = arm_ff | (wtr_ff != 4'h0);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_mrw2_first;
    rise && st_ff == ST_IDLE && cmd.cke && cmd.cs && !busy
      && cmd.ca[4:0] == OPC_MRW2;
  endsequence
  sequence s_second_edge;
    st_ff == ST_MRW2_2 && rise;
  endsequence

  a_burst_len_ui: assert property ($fell(oe_ff) |-> ui_ff == BURST_UI)
    else $error("read burst did not last sixteen intervals");
  // Zero byte must not pass for the undefined tail, so compare per interval
  a_reg_byte_lane: assert property (oe_ff && $changed(ui_ff)
    |-> dq_ff[7:0] == ((ui_ff <= REG_DATA_UI) ? byte_ff : 8'h00))
    else $error("register byte not on low lane for first intervals");
  a_upper_zero: assert property (oe_ff |-> dq_ff[15:8] == 8'h00)
    else $error("upper data byte driven during register read");
  a_ro_ignored: assert property (rise && st_ff == ST_MRW2_2
    && RO_MASK[wa_ff] |=> $stable(mem_ff[wa_ff]))
    else $error("write reached a read-only register");
  a_dbi_match: assert property ($rose(act_ff) |-> inv_ff ==
    (mem_ff[DBI_REG][DBI_BIT] && ones(~inv_ff ? byte_ff : ~byte_ff)
    > DBI_LIMIT))
    else $error("inversion flag disagrees with read byte");
  a_addr_taken: assert property (st_ff == ST_MRR2 && rise
    |=> ra_ff == $past(cmd.ca) && pend_ff)
    else $error("register read address not captured");
  // Second link edge follows within forty clocks of the first
  a_mrw_sequence: assert property (s_mrw2_first ##[1:40] s_second_edge
    |=> RO_MASK[wa_ff]
    || mem_ff[wa_ff] == {$past(op7_ff), $past(op6_ff), $past(cmd.ca)})
    else $error("register write second cycle not honoured");
  a_wtr_start: assert property (arm_ff && rise |=> wtr_ff == WTR_CYC)
    else $error("turnaround count did not start at rising edge");
  a_mrw_accept: assert property (rise && st_ff == ST_IDLE && cmd.cke
    && cmd.cs && !busy && cmd.ca[4:0] == OPC_MRW1
    |=> st_ff == ST_MRW1_2)
    else $error("register write not accepted");
endmodule : mra_core

//--- test/mra_ctl.sv
// Purpose: Controller model driving the command link pins
// Assumes: Link clock runs only inside a frame and rests low between
// Notes:   Gaps are in link cycles and cover every spacing rule
module mra_ctl
  import mra_pkg::*;
#(
  parameter int RD_GAP = 26,
  parameter int WR_GAP = 4
)
(
  // Clock
  input  wire logic clk_sys_in,
  // Command pins
  output mra_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  mra_pins_s pins_ff = '{1'b0, 1'b1, 1'b0, 6'h00};

  assign pins_out = pins_ff;

  // One link period; pins settle well before the rising link edge
  task automatic cyc(input logic sel, input logic [CA_W-1:0] ca);
    @(posedge clk_sys_in);
    pins_ff.cs <= sel;
    pins_ff.ca <= ca;
    repeat (4) @(posedge clk_sys_in);
    pins_ff.link_ck <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    pins_ff.link_ck <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : cyc

  // Released lines show the inverse of their last value
  task automatic des(input int n);
    for (int i = 0; i < n; i++) begin
      cyc(1'b0, ~pins_ff.ca);
    end
  endtask : des

  // No data reads, writes or power-down exits occur, so spacing against
  // them holds trivially
  task automatic config_reg_write_cmd(input logic [5:0] a, input logic [7:0] d);
    cyc(1'b1, {d[7], OPC_MRW1});
    cyc(1'b0, a);
    cyc(1'b1, {d[6], OPC_MRW2});
    cyc(1'b0, d[5:0]);
    des(WR_GAP);
  endtask : config_reg_write_cmd

  task automatic config_reg_read_cmd(input logic [5:0] a);
    cyc(1'b1, {1'b0, OPC_MRR1});
    cyc(1'b0, a);
    des(RD_GAP);
  endtask : config_reg_read_cmd
endmodule : mra_ctl

//--- test/testbench.sv
// Purpose: Self-checking bench for register reads, writes and turnaround
// Assumes: Controller model keeps all command spacing
// Notes:   Burst checks sample mid-interval, eight clocks per interval
module testbench
  import mra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] byte_v;
    logic       inv;
  } mra_exp_s;

  logic        clk_sys_in = 1'b0;
  logic        rst_b_in;
  logic        wr_last_strobe_in;
  mra_pins_s   pins;
  logic [15:0] dq_out;
  logic        dq_oe_out;
  logic        dmi_out;
  logic        dmi_oe_out;
  logic        rd_busy_out;
  logic        wtr_busy_out;
  mra_exp_s    exp_q[$];
  int          err_total = 0;
  int          cmp_count = 0;
  logic [31:0] lfsr;

  always #5 clk_sys_in = ~clk_sys_in;

  mra_ctl mra_ctl_i (.clk_sys_in(clk_sys_in), .pins_out(pins));

  mra_core mra_core_i (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .link_ck_in(pins.link_ck), .cke_in(pins.cke), .cs_in(pins.cs),
    .ca_in(pins.ca), .wr_last_strobe_in(wr_last_strobe_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dmi_out(dmi_out),
    .dmi_oe_out(dmi_oe_out), .rd_busy_out(rd_busy_out),
    .wtr_busy_out(wtr_busy_out));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic rd(input logic [5:0] a, input logic [7:0] b,
                    input logic inv);
    exp_q.push_back('{b, inv});
    mra_ctl_i.config_reg_read_cmd(a);
  endtask : rd

  // Burst watcher; an unexpected burst meets an unknown note
  initial begin : mon
    mra_exp_s e;
    int       n;
    forever begin
      @(posedge dq_oe_out);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n = 0;
      while (dq_oe_out === 1'b1 && n < 200) begin
        @(posedge clk_sys_in);
        #1;
        n++;
        if (n == 4) begin
          check({8'h00, dq_out[7:0]}, {8'h00, e.byte_v});
          check({15'h0, dmi_out}, {15'h0, e.inv});
          if (!e.inv) check(dq_out, {8'h00, e.byte_v});
          check({15'h0, rd_busy_out}, 16'h0001);
          check({15'h0, dmi_oe_out}, 16'h0001);
        end
        if (n == 28) check({8'h00, dq_out[7:0]}, {8'h00, e.byte_v});
        if (n == 36 && !e.inv) check(dq_out, 16'h0000);
      end
      check(16'(n), 16'd128);
      check({15'h0, rd_busy_out}, 16'h0000);
    end
  end

  initial begin : main
    logic [5:0] a;
    logic [7:0] d;
    rst_b_in = 1'b0;
    wr_last_strobe_in = 1'b0;
    lfsr = 32'hba30;
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rd(6'h00, RO_VALUE, 1'b0);
    rd(6'h01, REG_RST, 1'b0);
    mra_ctl_i.config_reg_write_cmd(6'h05, 8'ha5);
    rd(6'h05, RO_VALUE, 1'b0);
    $display("test reset_and_read_only done");
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      a = 6'd9 + 6'(lfsr[15:0] % 16'd55);
      d = lfsr[23:16];
      mra_ctl_i.config_reg_write_cmd(a, d);
      rd(a, d, 1'b0);
    end
    mra_ctl_i.config_reg_write_cmd(6'h3f, 8'h81);
    rd(6'h3f, 8'h81, 1'b0);
    $display("test write_read done");
    mra_ctl_i.config_reg_write_cmd(DBI_REG, 8'h40);
    mra_ctl_i.config_reg_write_cmd(6'h0a, 8'hff);
    rd(6'h0a, 8'h00, 1'b1);
    mra_ctl_i.config_reg_write_cmd(6'h0a, 8'h0f);
    rd(6'h0a, 8'h0f, 1'b0);
    mra_ctl_i.config_reg_write_cmd(DBI_REG, 8'h00);
    $display("test inversion done");
    @(posedge clk_sys_in);
    wr_last_strobe_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_last_strobe_in <= 1'b0;
    #1 check({15'h0, wtr_busy_out}, 16'h0001);
    mra_ctl_i.des(3);
    #1 check({15'h0, wtr_busy_out}, 16'h0000);
    $display("test turnaround done");
    repeat (10) @(posedge clk_sys_in);
    summarize();
  end

  // Expected run is under 10000 clocks
  initial begin : watchdog
    repeat (60000) @(posedge clk_sys_in);
    err_total++;
    summarize();
  end
endmodule : testbench
